// >>> eitl_core.sv
// External and timer interrupt request logic with APB register access
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Request flag reads pending state; writes to the flag itself change nothing.
// R2: Fetching the external vector clears the request flag.
// R3: Acknowledge write of 1 clears latch and flag; level mode also blocks sources.
// R4: Flag set again during service keeps the request alive after return.
// R5: Reset clears the request flag.
// R6: Flag requests an interrupt only while the enable bit is 1.
// R7: Reset sets the enable bit and the CPU interrupt mask.
// R8: Stop or wait execution sets the enable bit.
// R9: Setting enable with flag pending and mask clear requests at once.
// R10: With port interrupts on, low port lines OR with the pin.
// R11: The four port lines are enabled only as one group.
// R12: Port line requests are gated by the same enable bit.
// R13: Pin level output shows only the pin, not the OR.
// R14: Port lines trigger regardless of their direction setting.
// R15: Timer request rises on overflow or real-time event.
// R16: Timer flags and enables live in the timer status register.
// R17: Timer request only with mask clear; both causes share one vector.
// R18: Latch sets on pin falling edge or port line rising edge.
// R19: Edge mode sets flag from latch only; level mode also from level.
// R20: Acknowledge bit reads 0; writing 0 does nothing.
// R21: Pin inputs are synchronised before they touch the flag.
module eitl_core
    import eitl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic irq_pin_n_i,
    input wire logic [3:0] port_a_low_nibble_i,
    input wire logic timer_ovf_i,
    input wire logic rti_event_i,
    input wire logic ext_vector_fetch_i,
    input wire logic timer_vector_fetch_i,
    input wire logic stop_exec_i,
    input wire logic wait_exec_i,
    output logic ext_irq_req_o,
    output logic timer_irq_req_o,
    output logic [15:0] vec_addr_o,
    output logic irq_pin_level_o,
    output logic cpu_imask_o
);
    // ==================================================
    // Pin synchroniser
    eitl_pin_if pins ();

    // R21 pins synchronised first
    eitl_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .irq_pin_n_i(irq_pin_n_i),
        .pa_i(port_a_low_nibble_i),
        .pins(pins)
    );

    // ==================================================
    // State
    eitl_apb_st_t state;
    eitl_apb_st_t next_state;
    logic ext_request_flag;
    logic ext_enable_bit;
    logic lvl_block;
    logic comb_q;
    logic port_en;
    logic level_mode;
    logic imask;
    logic tof;
    logic rtif;
    logic tofe;
    logic rtie;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
        addr_hit = (a == reg_addr);
    endfunction

    // ==================================================
    // Bus decode
    wire hit_external_interrupt_status_control = addr_hit(paddr_i, EXTERNAL_INTERRUPT_STATUS_CONTROL_ADDR);
    wire hit_timer_status_control = addr_hit(paddr_i, TIMER_STATUS_CONTROL_ADDR);
    wire hit_ctrl = addr_hit(paddr_i, CTRL_ADDR);
    wire hit_any = hit_external_interrupt_status_control | hit_timer_status_control | hit_ctrl;
    // Writes land only at the edge where the master sees pready high
    wire xfer_end = psel_i & penable_i & (state == EITL_ST_ANSWER);
    wire wr_external_interrupt_status_control = xfer_end & pwrite_i & hit_external_interrupt_status_control;
    wire wr_timer_status_control = xfer_end & pwrite_i & hit_timer_status_control;
    wire wr_ctrl = xfer_end & pwrite_i & hit_ctrl;
    wire stop_wait = stop_exec_i | wait_exec_i;

    always_comb begin
        case (state)
            EITL_ST_IDLE: next_state = (psel_i & penable_i) ? EITL_ST_ANSWER : EITL_ST_IDLE;
            EITL_ST_ANSWER: next_state = EITL_ST_IDLE;
            default: next_state = EITL_ST_IDLE;
        endcase
    end

    // ==================================================
    // External source combining
    // R10 pin OR port lines
    // R11 one group enable
    // R14 direction not consulted
    wire comb = ~pins.irq_n | (port_en & (|pins.pa));
    // R18 edge into the latch
    wire edge_seen = comb & ~comb_q;
    // R20 only a written 1 acknowledges
    wire ack_wr = wr_external_interrupt_status_control & pwdata_i[EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_REQUEST_ACK];
    // R19 level term only in level mode
    // R3 an acknowledge holds the level term off
    wire level_term = level_mode & comb & ~lvl_block & ~ack_wr;
    wire flag_set = edge_seen | level_term;
    // R2 vector fetch clears
    // R3 acknowledge clears
    wire flag_clr = ack_wr | ext_vector_fetch_i;
    // R1 no direct write path; R4 set wins over any clear
    wire next_flag = flag_set | (ext_request_flag & ~flag_clr);
    // R3 level sources held inactive until they go quiet
    wire next_lvl_block = (ack_wr & level_mode) | (lvl_block & comb);
    // R8 stop and wait force enable
    wire next_enable = stop_wait ? 1'b1 : (wr_external_interrupt_status_control ? pwdata_i[EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_ENABLE_BIT] : ext_enable_bit);
    // Interrupt entry masks, low-power entry unmasks
    wire next_imask = (ext_vector_fetch_i | timer_vector_fetch_i) ? 1'b1 :
                      stop_wait ? 1'b0 :
                      wr_ctrl ? pwdata_i[CTRL_IMASK] : imask;

    // ==================================================
    // Timer causes
    // R15 overflow and real-time events set flags
    // R16 flags live in timer status register
    // Stop clears timer flags and enables so no stale request survives
    wire next_tof = timer_ovf_i | (tof & ~(wr_timer_status_control & pwdata_i[TIMER_STATUS_CONTROL_TOFR]) & ~stop_exec_i);
    wire next_rtif = rti_event_i | (rtif & ~(wr_timer_status_control & pwdata_i[TIMER_STATUS_CONTROL_RTIFR]) & ~stop_exec_i);
    wire next_tofe = stop_exec_i ? 1'b0 : (wr_timer_status_control ? pwdata_i[TIMER_STATUS_CONTROL_TOFE] : tofe);
    wire next_rtie = stop_exec_i ? 1'b0 : (wr_timer_status_control ? pwdata_i[TIMER_STATUS_CONTROL_RTIE] : rtie);

    // ==================================================
    // Requests toward the CPU
    // R6 enable gates the flag
    // R12 port lines share the gate
    // R9 request follows an enabling write at once
    wire next_ext_req = next_flag & next_enable & ~next_imask;
    // R17 timer gated by mask
    wire next_timer_req = ((next_tof & next_tofe) | (next_rtif & next_rtie)) & ~next_imask;
    // R17 both timer causes share one vector; external has higher priority
    wire [15:0] next_vec = next_ext_req ? EXT_VEC : TIMER_VEC;

    // ==================================================
    // Read data
    // R20 acknowledge reads 0
    wire [7:0] rd_external_interrupt_status_control = 8'(({7'h00, ext_enable_bit} << EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_ENABLE_BIT) | ({7'h00, ext_request_flag} << EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_REQUEST_FLAG));
    wire [7:0] rd_timer_status_control = 8'(({7'h00, tof} << TIMER_STATUS_CONTROL_TOF) | ({7'h00, rtif} << TIMER_STATUS_CONTROL_RTIF) |
                          ({7'h00, tofe} << TIMER_STATUS_CONTROL_TOFE) | ({7'h00, rtie} << TIMER_STATUS_CONTROL_RTIE));
    wire [7:0] rd_ctrl = 8'(({7'h00, port_en} << CTRL_PORT_EN) | ({7'h00, level_mode} << CTRL_LEVEL) |
                          ({7'h00, imask} << CTRL_IMASK));
    wire [7:0] rd_sel = hit_external_interrupt_status_control ? rd_external_interrupt_status_control : (hit_timer_status_control ? rd_timer_status_control : (hit_ctrl ? rd_ctrl : 8'h00));
    wire take = (next_state == EITL_ST_ANSWER);

    // ==================================================
    // Bus slave registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= EITL_ST_IDLE;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else if (ce_i) begin
            state <= next_state;
            pready_o <= take;
            pslverr_o <= take & ~hit_any;
            prdata_o <= (take & ~pwrite_i) ? {24'h000000, rd_sel} : 32'h00000000;
        end
    end

    // ==================================================
    // External request state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // R5 flag cleared
            ext_request_flag <= 1'b0;
            // R7 enable and mask set
            ext_enable_bit <= RST_EXT_ENABLE;
            imask <= RST_IMASK;
            lvl_block <= 1'b0;
            comb_q <= 1'b0;
        end else if (ce_i) begin
            ext_request_flag <= next_flag;
            ext_enable_bit <= next_enable;
            imask <= next_imask;
            lvl_block <= next_lvl_block;
            comb_q <= comb;
        end
    end

    // Mask options are held as soft configuration so one netlist covers all variants
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_en <= RST_PORT_EN;
            level_mode <= RST_LEVEL;
        end else if (ce_i && wr_ctrl) begin
            port_en <= pwdata_i[CTRL_PORT_EN];
            level_mode <= pwdata_i[CTRL_LEVEL];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tof <= 1'b0;
            rtif <= 1'b0;
            tofe <= 1'b0;
            rtie <= 1'b0;
        end else if (ce_i) begin
            tof <= next_tof;
            rtif <= next_rtif;
            tofe <= next_tofe;
            rtie <= next_rtie;
        end
    end

    // ==================================================
    // Outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_irq_req_o <= 1'b0;
            timer_irq_req_o <= 1'b0;
            vec_addr_o <= TIMER_VEC;
            irq_pin_level_o <= RST_PIN_N;
            cpu_imask_o <= RST_IMASK;
        end else if (ce_i) begin
            ext_irq_req_o <= next_ext_req;
            timer_irq_req_o <= next_timer_req;
            vec_addr_o <= next_vec;
            // R13 pin alone, for the branch-on-level test
            irq_pin_level_o <= pins.irq_n;
            cpu_imask_o <= next_imask;
        end
    end

    // ==================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_r1_write_ignored;
        (ce_i && wr_external_interrupt_status_control && pwdata_i[EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_REQUEST_FLAG] && !ext_request_flag && !flag_set) |=> !ext_request_flag;
    endproperty
    a_r1_write_ignored: assert property (p_r1_write_ignored) else $error("flag set by a write"); // R1

    property p_r2_fetch_clears;
        (ce_i && ext_vector_fetch_i && !flag_set) |=> !ext_request_flag;
    endproperty
    a_r2_fetch_clears: assert property (p_r2_fetch_clears) else $error("flag kept over vector fetch"); // R2

    property p_r3_ack_blocks;
        (ce_i && ack_wr && level_mode && !edge_seen) |=> (!ext_request_flag && lvl_block);
    endproperty
    a_r3_ack_blocks: assert property (p_r3_ack_blocks) else $error("acknowledge did not clear"); // R3

    property p_r6_gate;
        (ce_i && !next_enable) |=> !ext_irq_req_o;
    endproperty
    a_r6_gate: assert property (p_r6_gate) else $error("request while disabled"); // R6

    property p_r8_lowpower;
        (ce_i && stop_wait) |=> (ext_enable_bit && !cpu_imask_o);
    endproperty
    a_r8_lowpower: assert property (p_r8_lowpower) else $error("enable not set by stop or wait"); // R8

    property p_r9_immediate;
        (ce_i && ext_request_flag && !flag_clr && wr_external_interrupt_status_control && pwdata_i[EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_ENABLE_BIT] && !next_imask) |=> ext_irq_req_o;
    endproperty
    a_r9_immediate: assert property (p_r9_immediate) else $error("no request after enabling"); // R9

    property p_r15_timer;
        (ce_i && timer_ovf_i && !stop_exec_i) |=> tof;
    endproperty
    a_r15_timer: assert property (p_r15_timer) else $error("overflow flag missed"); // R15

    property p_r17_masked;
        timer_irq_req_o |-> (!cpu_imask_o && vec_addr_o == (ext_irq_req_o ? EXT_VEC : TIMER_VEC));
    endproperty
    a_r17_masked: assert property (p_r17_masked) else $error("timer request while masked"); // R17

    property p_r18_edge;
        (ce_i && edge_seen) |=> ext_request_flag;
    endproperty
    a_r18_edge: assert property (p_r18_edge) else $error("edge did not set flag"); // R18

    property p_r20_ack_reads_zero;
        (ce_i && take && !pwrite_i && hit_external_interrupt_status_control) |=> !prdata_o[EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_REQUEST_ACK];
    endproperty
    a_r20_ack_reads_zero: assert property (p_r20_ack_reads_zero) else $error("acknowledge bit read as 1"); // R20

    property p_r4_set_wins;
        (ce_i && flag_set) |=> ext_request_flag;
    endproperty
    a_r4_set_wins: assert property (p_r4_set_wins) else $error("flag set lost to a clear"); // R4

    property p_r10_port_edge;
        (ce_i && port_en && (|pins.pa) && !comb_q) |=> ext_request_flag;
    endproperty
    a_r10_port_edge: assert property (p_r10_port_edge) else $error("port line edge did not set flag"); // R10

    property p_r11_ports_off;
        (ce_i && !port_en && pins.irq_n && !ext_request_flag) |=> !ext_request_flag;
    endproperty
    a_r11_ports_off: assert property (p_r11_ports_off) else $error("flag set with port lines off"); // R11

    property p_r12_port_gate;
        (ce_i && port_en && (|pins.pa) && !next_enable) |=> !ext_irq_req_o;
    endproperty
    a_r12_port_gate: assert property (p_r12_port_gate) else $error("port request while disabled"); // R12

    property p_r13_pin_only;
        ce_i |=> (irq_pin_level_o == $past(pins.irq_n));
    endproperty
    a_r13_pin_only: assert property (p_r13_pin_only) else $error("pin level output differs from pin"); // R13

    property p_r15_rti;
        (ce_i && rti_event_i) |=> rtif;
    endproperty
    a_r15_rti: assert property (p_r15_rti) else $error("real-time flag missed"); // R15

    property p_r19_edge_only;
        (ce_i && !level_mode && !edge_seen && !ext_request_flag) |=> !ext_request_flag;
    endproperty
    a_r19_edge_only: assert property (p_r19_edge_only) else $error("flag set without edge in edge mode"); // R19

    property p_r20_zero_write;
        (ce_i && wr_external_interrupt_status_control && !pwdata_i[EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_REQUEST_ACK] && ext_request_flag && !ext_vector_fetch_i) |=> ext_request_flag;
    endproperty
    a_r20_zero_write: assert property (p_r20_zero_write) else $error("writing 0 to acknowledge cleared flag"); // R20

    property p_apb_answer;
        (ce_i && psel_i && penable_i && !pready_o) |=> pready_o;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("access not answered in one cycle");
endmodule
`default_nettype wire

// >>> eitl_pkg.sv
// Package with register map, field positions and reset values of the interrupt logic
`default_nettype none
package eitl_pkg;

    // ==================================================
    // Register indices and byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] TIMER_STATUS_CONTROL_IDX = 8'h08;
    localparam logic [ADDR_W-1:0] EXTERNAL_INTERRUPT_STATUS_CONTROL_IDX = 8'h0A;
    localparam logic [ADDR_W-1:0] CTRL_IDX = 8'h0C;
    localparam logic [ADDR_W-1:0] TIMER_STATUS_CONTROL_ADDR = ADDR_W'({TIMER_STATUS_CONTROL_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] EXTERNAL_INTERRUPT_STATUS_CONTROL_ADDR = ADDR_W'({EXTERNAL_INTERRUPT_STATUS_CONTROL_IDX, 2'b00});
    localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'({CTRL_IDX, 2'b00});

    // ==================================================
    // Field positions
    localparam int EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_ENABLE_BIT = 7;
    localparam int EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_REQUEST_FLAG = 3;
    localparam int EXTERNAL_INTERRUPT_STATUS_CONTROL_EXT_REQUEST_ACK = 1;
    localparam int TIMER_STATUS_CONTROL_TOF = 7;
    localparam int TIMER_STATUS_CONTROL_RTIF = 6;
    localparam int TIMER_STATUS_CONTROL_TOFE = 5;
    localparam int TIMER_STATUS_CONTROL_RTIE = 4;
    localparam int TIMER_STATUS_CONTROL_TOFR = 3;
    localparam int TIMER_STATUS_CONTROL_RTIFR = 2;
    localparam int CTRL_PORT_EN = 0;
    localparam int CTRL_LEVEL = 1;
    localparam int CTRL_IMASK = 2;

    // ==================================================
    // Reset values
    localparam logic RST_EXT_ENABLE = 1'b1;
    localparam logic RST_IMASK = 1'b1;
    localparam logic RST_PORT_EN = 1'b0;
    localparam logic RST_LEVEL = 1'b0;
    localparam logic RST_PIN_N = 1'b1;

    // ==================================================
    // Vector addresses
    localparam logic [15:0] EXT_VEC = 16'h03FA;
    localparam logic [15:0] TIMER_VEC = 16'h03F8;

    typedef enum logic [1:0] {
        EITL_ST_IDLE = 2'b00,
        EITL_ST_ANSWER = 2'b01
    } eitl_apb_st_t;

endpackage
`default_nettype wire

// >>> eitl_pin_if.sv
// Interface carrying the filtered interrupt pin levels between synchroniser and core
`timescale 1ns/1ps
`default_nettype none
interface eitl_pin_if;
    logic irq_n;
    logic [3:0] pa;
    modport sync (output irq_n, output pa);
    modport core (input irq_n, input pa);
endinterface
`default_nettype wire

// >>> eitl_sync.sv
// Three-stage synchroniser with agreement filter for the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module eitl_sync
    import eitl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic irq_pin_n_i,
    input wire logic [3:0] pa_i,
    eitl_pin_if.sync pins
);
    // ==================================================
    // Stages; bit 4 is the pin, bits 3..0 the port lines
    localparam logic [4:0] RST_VEC = {RST_PIN_N, 4'h0};
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] level;

    // Pin inputs synchronised before use
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1 <= RST_VEC;
            s2 <= RST_VEC;
            s3 <= RST_VEC;
        end else if (ce_i) begin
            s1 <= {irq_pin_n_i, pa_i};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A bit changes only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_filt
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    level[g] <= RST_VEC[g];
                end else if (ce_i && (s2[g] == s3[g])) begin
                    level[g] <= s3[g];
                end
            end
        end
    endgenerate

    assign pins.irq_n = level[4];
    assign pins.pa = level[3:0];
endmodule
`default_nettype wire

// >>> eitl_cpu_model.sv
// CPU side model: takes the vector a set number of cycles after a request
`timescale 1ns/1ps
`default_nettype none
module eitl_cpu_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic auto_i,
    input wire logic [3:0] delay_i,
    input wire logic ext_req_i,
    input wire logic timer_req_i,
    output logic ext_fetch_o,
    output logic timer_fetch_o
);
    logic [3:0] cnt;

    // Count restarts after a fetch, since the request only falls one cycle later
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
            ext_fetch_o <= 1'b0;
            timer_fetch_o <= 1'b0;
        end else if (!auto_i || !(ext_req_i || timer_req_i) || ext_fetch_o || timer_fetch_o) begin
            cnt <= 4'h0;
            ext_fetch_o <= 1'b0;
            timer_fetch_o <= 1'b0;
        end else if (cnt >= delay_i) begin
            cnt <= 4'h0;
            // External vector sits higher in the table, so it is served first
            ext_fetch_o <= ext_req_i;
            timer_fetch_o <= !ext_req_i;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the external and timer interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import eitl_pkg::*;
;
    localparam logic [ADDR_W-1:0] A_TIM = 8'h20;
    localparam logic [ADDR_W-1:0] A_EXT = 8'h28;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic irq_n = 1'b1;
    logic [3:0] pa = 4'h0;
    logic [3:0] ev = 4'h0;
    logic auto = 1'b0;
    logic ce = 1'b1;
    logic [3:0] dly = 4'h2;
    logic [31:0] prdata;
    logic [15:0] vec;
    logic pready, pslverr, ext_fetch, tim_fetch, ext_req, tim_req, pin_lvl, imask;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    eitl_core dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_pin_n_i(irq_n), .port_a_low_nibble_i(pa), .timer_ovf_i(ev[0]),
        .rti_event_i(ev[1]), .ext_vector_fetch_i(ext_fetch), .timer_vector_fetch_i(tim_fetch),
        .stop_exec_i(ev[2]), .wait_exec_i(ev[3]), .ext_irq_req_o(ext_req), .timer_irq_req_o(tim_req),
        .vec_addr_o(vec), .irq_pin_level_o(pin_lvl), .cpu_imask_o(imask));

    eitl_cpu_model cpu (.clk_i(clk), .rst_n_i(rst_n), .auto_i(auto), .delay_i(dly), .ext_req_i(ext_req),
        .timer_req_i(tim_req), .ext_fetch_o(ext_fetch), .timer_fetch_o(tim_fetch));

    // ==========================================
    // Expectations and checks
    function automatic logic [31:0] w32(input logic x);
        return {31'h0, x};
    endfunction
    function automatic logic [31:0] external_interrupt_status_control(input logic en, input logic fl);
        return (w32(en) << 7) | (w32(fl) << 3);
    endfunction
    function automatic logic [31:0] timer_status_control(input logic [1:0] fl, input logic [1:0] en);
        return {24'h0, fl, en, 4'h0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================
    // Bus and stimulus tasks
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Read at the rising edge, so the values seen are those that stood before it
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk(32'(n), 32'h2);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk(w32(e), w32(xe));
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input int k);
        ev <= 4'(1 << k);
        @(posedge clk);
        ev <= 4'h0;
        @(posedge clk);
    endtask
    task automatic wait_ext(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ext_req !== v && n < 30);
        chk(w32(ext_req), w32(v));
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("mismatch at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    initial begin
        logic [1:0] en;
        logic [1:0] fl;
        int b;
        void'($urandom(32'h07C5));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(A_EXT, external_interrupt_status_control(1'b1, 1'b0), 1'b0);
        rd(CTRL_ADDR, 32'h4, 1'b0);
        chk(w32(imask), 32'h1);
        rd(8'h04, 32'h0, 1'b1);
        wr(A_EXT, 32'h0A);
        rd(A_EXT, external_interrupt_status_control(1'b0, 1'b0), 1'b0);
        irq_n <= 1'b0;
        settle(10);
        rd(A_EXT, external_interrupt_status_control(1'b0, 1'b1), 1'b0);
        chk(w32(pin_lvl), 32'h0);
        wr(CTRL_ADDR, 32'h0);
        settle(3);
        chk(w32(ext_req), 32'h0);
        wr(A_EXT, 32'h80);
        wait_ext(1'b1);
        chk(32'(vec), 32'h3FA);
        wr(A_EXT, 32'h82);
        rd(A_EXT, external_interrupt_status_control(1'b1, 1'b0), 1'b0);
        irq_n <= 1'b1;
        auto <= 1'b1;
        dly <= 4'(2 + $urandom % 8);
        settle(6);
        irq_n <= 1'b0;
        wait_ext(1'b1);
        wait_ext(1'b0);
        rd(A_EXT, external_interrupt_status_control(1'b1, 1'b0), 1'b0);
        // New edge while the mask is still set from the fetch
        irq_n <= 1'b1;
        auto <= 1'b0;
        settle(6);
        irq_n <= 1'b0;
        settle(10);
        chk(w32(ext_req), 32'h0);
        wr(CTRL_ADDR, 32'h0);
        wait_ext(1'b1);
        wr(A_EXT, 32'h82);
        irq_n <= 1'b1;
        wr(CTRL_ADDR, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(A_EXT, k ? 32'h80 : 32'h00);
            pa <= 4'(1 << ($urandom % 4));
            settle(10);
            chk(w32(ext_req), 32'(k));
            chk(w32(pin_lvl), 32'h1);
            wr(A_EXT, 32'h82);
            pa <= 4'h0;
            settle(6);
        end
        wr(CTRL_ADDR, 32'h0);
        pa <= 4'hF;
        settle(10);
        rd(A_EXT, external_interrupt_status_control(1'b1, 1'b0), 1'b0);
        pa <= 4'h0;
        wr(CTRL_ADDR, 32'h2);
        irq_n <= 1'b0;
        wait_ext(1'b1);
        wr(A_EXT, 32'h82);
        rd(A_EXT, external_interrupt_status_control(1'b1, 1'b0), 1'b0);
        irq_n <= 1'b1;
        for (int k = 2; k < 4; k++) begin
            wr(CTRL_ADDR, 32'h4);
            wr(A_EXT, 32'h0);
            pulse(k);
            rd(A_EXT, external_interrupt_status_control(1'b1, 1'b0), 1'b0);
            chk(w32(imask), 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            en = 2'($urandom % 4);
            b = i % 2;
            fl = b ? 2'b01 : 2'b10;
            wr(A_TIM, 32'(en) << 4);
            pulse(b);
            settle(2);
            chk(w32(tim_req), w32(|(fl & en)));
            chk(32'(vec), 32'h3F8);
            rd(A_TIM, timer_status_control(fl, en), 1'b0);
            wr(A_TIM, 32'h0C);
        end
        wr(CTRL_ADDR, 32'h4);
        wr(A_TIM, 32'h30);
        pulse(0);
        settle(2);
        chk(w32(tim_req), 32'h0);
        // A frozen clock enable must swallow the real-time event
        ce <= 1'b0;
        pulse(1);
        ce <= 1'b1;
        rd(A_TIM, timer_status_control(2'b10, 2'b11), 1'b0);
        // Mid-run reset with a pending flag
        irq_n <= 1'b0;
        settle(10);
        rd(A_EXT, external_interrupt_status_control(1'b1, 1'b1), 1'b0);
        rst_n <= 1'b0;
        irq_n <= 1'b1;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(A_EXT, external_interrupt_status_control(1'b1, 1'b0), 1'b0);
        chk(w32(imask), 32'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
